// *** rtl/afp_regs.vh ***
// opcode codes, correction constants, limits and reset values for the alu datapath
`ifndef AFP_REGS_VH
`define AFP_REGS_VH

`define AFP_OP_W        5
`define AFP_OP_NOP      5'h00
`define AFP_OP_ADD      5'h01
`define AFP_OP_ADD_WITH_CARRY_OP     5'h02
`define AFP_OP_SUB      5'h03
`define AFP_OP_MUL      5'h04
`define AFP_OP_DIV      5'h05
`define AFP_OP_DADJ     5'h06
`define AFP_OP_RRC      5'h07
`define AFP_OP_RLC      5'h08
`define AFP_OP_CMPBR    5'h09
`define AFP_OP_P_AND    5'h0a
`define AFP_OP_P_OR     5'h0b
`define AFP_OP_P_XOR    5'h0c
`define AFP_OP_P_TBCJ   5'h0d
`define AFP_OP_P_CPL    5'h0e
`define AFP_OP_P_INC    5'h0f
`define AFP_OP_P_DEC    5'h10
`define AFP_OP_P_DECREMENT_JUMP_NONZERO_OP   5'h11
`define AFP_OP_P_MOVC   5'h12
`define AFP_OP_P_CLRB   5'h13
`define AFP_OP_P_BIT_SET_OP   5'h14
`define AFP_OP_P_RDBIT  5'h15
`define AFP_OP_P_RDBYTE 5'h16
`define AFP_OP_CPLBYTE  5'h17

`define AFP_NIB_LIMIT   4'h9
`define AFP_LO_FIX      8'h06
`define AFP_HI_FIX      8'h60
`define AFP_BCD_LIMIT   9'h099
`define AFP_MUL_LIMIT   16'h00ff

`define AFP_ACC_RST     8'h00
`define AFP_B_RST       8'h00
`define AFP_LATCH_RST   8'hff

`endif

// *** rtl/afp_bit_merge.v ***
// single-bit insertion into a whole port byte
`timescale 1ns/100ps
`default_nettype none
module afp_bit_merge #(
  parameter WIDTH = 8,
  parameter SEL_W = 3
) (
  input  wire [WIDTH-1:0] byte_in,
  input  wire [SEL_W-1:0] bit_sel,
  input  wire             bit_val,
  output wire [WIDTH-1:0] byte_out,
  output wire             bit_old
);
  wire [WIDTH-1:0] mask;

  assign mask     = {{(WIDTH-1){1'b0}}, 1'b1} << bit_sel;
  assign byte_out = bit_val ? (byte_in | mask) : (byte_in & ~mask);
  assign bit_old  = |(byte_in & mask);
endmodule // afp_bit_merge
`default_nettype wire

// *** rtl/afp_alu_flags.v ***
// alu datapath: flag generation and port read-modify-write
//
// Notes on behaviour
// RULE_01 - rmw instructions with a port destination take the latch, not pins
// RULE_02 - plain port bit or byte reads take the sampled pin level
// RULE_03 - rmw set: and, or, xor, test-clear-jump, cpl, inc, dec, decrement_jump_nonzero_op, bit ops
// RULE_04 - bit writes read whole latch byte, change one bit, write byte back
// RULE_05 - additions set carry on carry out of bit 7
// RULE_06 - additions set overflow as carry6 xor carry7
// RULE_07 - additions set nibble carry on carry out of bit 3
// RULE_08 - add-with-carry adds incoming carry; plain add ignores it
// RULE_09 - subtract takes source and carry; carry marks borrow at bit 7
// RULE_10 - subtract overflow when exactly one of bits 6, 7 borrows
// RULE_11 - subtract nibble carry marks borrow at bit 3
// RULE_12 - multiply: unsigned product, low byte to accumulator, high to b
// RULE_13 - multiply clears carry; overflow when product above 255
// RULE_14 - divide: quotient to accumulator, remainder to b
// RULE_15 - divide clears carry; overflow only when divisor is zero
// RULE_16 - decimal adjust adds 06h on nibble carry or low nibble above 9
// RULE_17 - decimal adjust adds 60h on old carry or low correction applied
// RULE_18 - decimal adjust sets carry when result exceeds 99h
// RULE_19 - rotate right: bit 0 to carry, carry to bit 7
// RULE_20 - rotate left: bit 7 to carry, carry to bit 0
// RULE_21 - compare-branch jumps when operands differ
// RULE_22 - compare-branch carry set when source greater than destination
// RULE_23 - other instructions leave carry, overflow, nibble carry alone
`timescale 1ns/100ps
`default_nettype none
`include "afp_regs.vh"
module afp_alu_flags #(
  parameter WIDTH = 8
) (
  input  wire                 clock,
  input  wire                 rst_b,
  input  wire                 op_valid,
  input  wire [`AFP_OP_W-1:0] op_code,
  input  wire [WIDTH-1:0]     src_operand,
  input  wire [WIDTH-1:0]     dst_operand,
  input  wire [2:0]           port_bit_sel,
  input  wire [WIDTH-1:0]     port_pins,
  output reg  [WIDTH-1:0]     accumulator_reg,
  output reg  [WIDTH-1:0]     b_reg,
  output reg  [WIDTH-1:0]     port_latch,
  output reg                  carry_flag,
  output reg                  signed_overflow_flag,
  output reg                  nibble_carry_flag,
  output reg                  branch_taken,
  output reg                  port_read_bit,
  output reg  [WIDTH-1:0]     port_read_byte,
  output reg                  div_by_zero,
  output reg                  op_done
);
  reg  [WIDTH-1:0] next_acc;
  reg  [WIDTH-1:0] next_b;
  reg  [WIDTH-1:0] next_latch;
  reg              next_cy;
  reg              next_ov;
  reg              next_ac;
  reg              next_branch;
  reg              next_rd_bit;
  reg  [WIDTH-1:0] next_rd_byte;
  reg              next_dz;

  reg  [4:0]       lo_sum;
  reg  [3:0]       mid_sum;
  reg  [1:0]       top_sum;
  reg              cin;
  reg              c3;
  reg              c6;
  reg              c7;
  reg  [WIDTH-1:0] sum;
  reg  [4:0]       lo_dif;
  reg  [3:0]       mid_dif;
  reg  [1:0]       top_dif;
  reg              b3;
  reg              b6;
  reg              b7;
  reg  [WIDTH-1:0] dif;
  reg  [2*WIDTH-1:0] product;
  reg  [WIDTH-1:0] quot;
  reg  [WIDTH-1:0] rem;
  reg  [WIDTH:0]   bcd;
  reg              lo_fix;
  reg              hi_fix;
  reg              bit_val;

  wire [WIDTH-1:0] merged;
  wire             latch_bit;

  // bit ops read the full latch byte and write it all back
  afp_bit_merge #(
    .WIDTH (WIDTH),
    .SEL_W (3)
  ) u_merge (
    .byte_in  (port_latch), // RULE_04
    .bit_sel  (port_bit_sel),
    .bit_val  (bit_val),
    .byte_out (merged),
    .bit_old  (latch_bit)
  );

  always @* begin
    cin = (op_code == `AFP_OP_ADD_WITH_CARRY_OP) ? carry_flag : 1'b0; // RULE_08
    lo_sum  = {1'b0, accumulator_reg[3:0]} + {1'b0, src_operand[3:0]} + {4'h0, cin};
    c3      = lo_sum[4]; // RULE_07
    mid_sum = {1'b0, accumulator_reg[6:4]} + {1'b0, src_operand[6:4]} + {3'h0, c3};
    c6      = mid_sum[3];
    top_sum = {1'b0, accumulator_reg[7]} + {1'b0, src_operand[7]} + {1'b0, c6};
    c7      = top_sum[1]; // RULE_05
    sum     = {top_sum[0], mid_sum[2:0], lo_sum[3:0]};
    // borrows chained per segment
    lo_dif  = {1'b0, accumulator_reg[3:0]} - {1'b0, src_operand[3:0]} - {4'h0, carry_flag};
    b3      = lo_dif[4]; // RULE_11
    mid_dif = {1'b0, accumulator_reg[6:4]} - {1'b0, src_operand[6:4]} - {3'h0, b3};
    b6      = mid_dif[3];
    top_dif = {1'b0, accumulator_reg[7]} - {1'b0, src_operand[7]} - {1'b0, b6};
    b7      = top_dif[1]; // RULE_09
    dif     = {top_dif[0], mid_dif[2:0], lo_dif[3:0]};
    product = accumulator_reg * b_reg; // RULE_12
    if (b_reg == {WIDTH{1'b0}}) begin
      quot = {WIDTH{1'b1}};
      rem  = accumulator_reg;
    end else begin
      quot = accumulator_reg / b_reg; // RULE_14
      rem  = accumulator_reg % b_reg;
    end
    lo_fix = nibble_carry_flag || (accumulator_reg[3:0] > `AFP_NIB_LIMIT); // RULE_16
    hi_fix = carry_flag || lo_fix; // RULE_17
    bcd    = {1'b0, accumulator_reg}
           + (lo_fix ? {1'b0, `AFP_LO_FIX} : 9'h000)
           + (hi_fix ? {1'b0, `AFP_HI_FIX} : 9'h000);
    bit_val = 1'b0;
    case (op_code)
      `AFP_OP_P_MOVC: bit_val = carry_flag;
      `AFP_OP_P_BIT_SET_OP: bit_val = 1'b1;
      `AFP_OP_P_CPL:  bit_val = ~latch_bit;
      default:        bit_val = 1'b0;
    endcase
  end

  always @* begin
    // defaults keep every flag as it stands; branch_taken defaults to 0
    next_acc     = accumulator_reg;
    next_b       = b_reg;
    next_latch   = port_latch;
    next_cy      = carry_flag; // RULE_23
    next_ov      = signed_overflow_flag; // RULE_23
    next_ac      = nibble_carry_flag; // RULE_23
    next_branch  = 1'b0;
    next_rd_bit  = port_read_bit;
    next_rd_byte = port_read_byte;
    next_dz      = div_by_zero;
    if (op_valid) begin
      case (op_code)
        `AFP_OP_ADD, `AFP_OP_ADD_WITH_CARRY_OP: begin
          next_acc = sum;
          next_cy  = c7; // RULE_05
          next_ov  = c6 ^ c7; // RULE_06
          next_ac  = c3; // RULE_07
        end
        `AFP_OP_SUB: begin
          next_acc = dif;
          next_cy  = b7; // RULE_09
          next_ov  = b6 ^ b7; // RULE_10
          next_ac  = b3; // RULE_11
        end
        `AFP_OP_MUL: begin
          next_acc = product[WIDTH-1:0];
          next_b   = product[2*WIDTH-1:WIDTH]; // RULE_12
          next_cy  = 1'b0;
          next_ov  = (product > `AFP_MUL_LIMIT); // RULE_13
        end
        `AFP_OP_DIV: begin
          next_acc = quot;
          next_b   = rem;
          next_cy  = 1'b0;
          next_ov  = (b_reg == {WIDTH{1'b0}}); // RULE_15
          next_dz  = (b_reg == {WIDTH{1'b0}});
        end
        `AFP_OP_DADJ: begin
          next_acc = bcd[WIDTH-1:0];
          next_cy  = (bcd > `AFP_BCD_LIMIT); // RULE_18
        end
        `AFP_OP_RRC: begin
          next_acc = {carry_flag, accumulator_reg[WIDTH-1:1]};
          next_cy  = accumulator_reg[0]; // RULE_19
        end
        `AFP_OP_RLC: begin
          next_acc = {accumulator_reg[WIDTH-2:0], carry_flag};
          next_cy  = accumulator_reg[WIDTH-1]; // RULE_20
        end
        `AFP_OP_CPLBYTE: begin
          next_acc = ~accumulator_reg;
        end
        `AFP_OP_CMPBR: begin
          next_branch = (dst_operand != src_operand); // RULE_21
          next_cy     = (src_operand > dst_operand); // RULE_22
        end
        // port rmw ops operate on the latch; plain bit and byte reads take the pins
        `AFP_OP_P_AND: begin
          next_latch = port_latch & src_operand; // RULE_01
        end
        `AFP_OP_P_OR: begin
          next_latch = port_latch | src_operand; // RULE_03
        end
        `AFP_OP_P_XOR: begin
          next_latch = port_latch ^ src_operand; // RULE_03
        end
        `AFP_OP_P_INC: begin
          next_latch = port_latch + {{(WIDTH-1){1'b0}}, 1'b1}; // RULE_03
        end
        `AFP_OP_P_DEC: begin
          next_latch = port_latch - {{(WIDTH-1){1'b0}}, 1'b1}; // RULE_03
        end
        `AFP_OP_P_DECREMENT_JUMP_NONZERO_OP: begin
          next_latch  = port_latch - {{(WIDTH-1){1'b0}}, 1'b1}; // RULE_03
          next_branch = (port_latch != {{(WIDTH-1){1'b0}}, 1'b1});
        end
        `AFP_OP_P_TBCJ: begin
          next_latch  = merged; // RULE_01
          next_branch = latch_bit;
        end
        `AFP_OP_P_CPL, `AFP_OP_P_MOVC, `AFP_OP_P_CLRB, `AFP_OP_P_BIT_SET_OP: begin
          next_latch = merged; // RULE_04
        end
        `AFP_OP_P_RDBIT: begin
          next_rd_bit = port_pins[port_bit_sel]; // RULE_02
        end
        `AFP_OP_P_RDBYTE: begin
          next_rd_byte = port_pins; // RULE_02
        end
        default: begin
          next_acc = accumulator_reg;
        end
      endcase
    end
  end

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      accumulator_reg      <= `AFP_ACC_RST;
      b_reg                <= `AFP_B_RST;
      port_latch           <= `AFP_LATCH_RST;
      carry_flag           <= 1'b0;
      signed_overflow_flag <= 1'b0;
      nibble_carry_flag    <= 1'b0;
      branch_taken         <= 1'b0;
      port_read_bit        <= 1'b0;
      port_read_byte       <= 8'h00;
      div_by_zero          <= 1'b0;
      op_done              <= 1'b0;
    end else begin
      accumulator_reg      <= next_acc;
      b_reg                <= next_b;
      port_latch           <= next_latch;
      carry_flag           <= next_cy;
      signed_overflow_flag <= next_ov;
      nibble_carry_flag    <= next_ac;
      branch_taken         <= next_branch;
      port_read_bit        <= next_rd_bit;
      port_read_byte       <= next_rd_byte;
      div_by_zero          <= next_dz;
      op_done              <= op_valid;
    end
  end
endmodule // afp_alu_flags
`default_nettype wire

// *** test/afp_alu_properties.sv ***
// assertion checker for the alu flag and port rmw datapath
`timescale 1ns/100ps
`default_nettype none
`include "afp_regs.vh"
module afp_alu_props #(
  parameter WIDTH = 8
) (
  input wire logic                 clock,
  input wire logic                 rst_b,
  input wire logic                 op_valid,
  input wire logic [`AFP_OP_W-1:0] op_code,
  input wire logic [WIDTH-1:0]     src_operand,
  input wire logic [WIDTH-1:0]     dst_operand,
  input wire logic [2:0]           port_bit_sel,
  input wire logic [WIDTH-1:0]     port_pins,
  input wire logic [WIDTH-1:0]     accumulator_reg,
  input wire logic [WIDTH-1:0]     b_reg,
  input wire logic [WIDTH-1:0]     port_latch,
  input wire logic                 carry_flag,
  input wire logic                 signed_overflow_flag,
  input wire logic                 nibble_carry_flag,
  input wire logic                 branch_taken,
  input wire logic                 port_read_bit
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence s_op(logic [`AFP_OP_W-1:0] c);
    op_valid && op_code == c;
  endsequence
  property p_add;
    s_op(`AFP_OP_ADD) |=> {carry_flag, accumulator_reg} == $past(accumulator_reg) + $past(src_operand)
      && nibble_carry_flag == ($past(accumulator_reg[3:0]) + $past(src_operand[3:0]) > 5'h0f);
  endproperty
  a_add: assert property (p_add) else $error("add result wrong");
  property p_bit_set_op;
    s_op(`AFP_OP_P_BIT_SET_OP) |=> port_latch == ($past(port_latch) | (8'h01 << $past(port_bit_sel)));
  endproperty
  a_bit_set_op: assert property (p_bit_set_op) else $error("bit set not from latch");
  property p_rdbit;
    s_op(`AFP_OP_P_RDBIT) |=> port_read_bit == $past(port_pins[port_bit_sel]);
  endproperty
  a_rdbit: assert property (p_rdbit) else $error("bit read not from pins");
  property p_mul;
    s_op(`AFP_OP_MUL) |=> {b_reg, accumulator_reg} == $past(accumulator_reg) * $past(b_reg)
      && !carry_flag && signed_overflow_flag == (b_reg != 8'h00);
  endproperty
  a_mul: assert property (p_mul) else $error("multiply wrong");
  property p_div0;
    s_op(`AFP_OP_DIV) ##0 (b_reg == 8'h00) |=> signed_overflow_flag && !carry_flag;
  endproperty
  a_div0: assert property (p_div0) else $error("divide by zero flags wrong");
  property p_rrc;
    s_op(`AFP_OP_RRC) |=> {accumulator_reg, carry_flag} == {$past(carry_flag), $past(accumulator_reg)};
  endproperty
  a_rrc: assert property (p_rrc) else $error("rotate right wrong");
  property p_cmp;
    s_op(`AFP_OP_CMPBR) |=> branch_taken == $past(src_operand != dst_operand)
      && carry_flag == $past(src_operand > dst_operand);
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare branch wrong");
  property p_keep;
    s_op(`AFP_OP_P_OR) |=> $stable({carry_flag, signed_overflow_flag, nibble_carry_flag});
  endproperty
  a_keep: assert property (p_keep) else $error("flags moved on port or");
endmodule // afp_alu_props
bind afp_alu_flags afp_alu_props #(.WIDTH(WIDTH)) u_props (.clock, .rst_b, .op_valid, .op_code,
  .src_operand, .dst_operand, .port_bit_sel, .port_pins, .accumulator_reg, .b_reg, .port_latch,
  .carry_flag, .signed_overflow_flag, .nibble_carry_flag, .branch_taken, .port_read_bit);
`default_nettype wire

// *** test/tb.sv ***
// self-checking bench for the alu flag and port rmw datapath
`timescale 1ns/100ps
`default_nettype none
`include "afp_regs.vh"
module tb;
  logic                 clock, rst_b, op_valid, m_c, m_ov, m_ac, m_rbit, m_dz;
  logic [`AFP_OP_W-1:0] op_code;
  logic [7:0]           src_operand, dst_operand, port_pins, m_acc, m_b, m_lat, m_rbyte;
  logic [2:0]           port_bit_sel;
  wire  [7:0]           accumulator_reg, b_reg, port_latch, port_read_byte;
  wire                  carry_flag, signed_overflow_flag, nibble_carry_flag;
  wire                  branch_taken, port_read_bit, div_by_zero, op_done;
  integer               failures, check_count, seed, i;
  integer               cycles = 0;
  wire  [38:0]          seen = {accumulator_reg, b_reg, port_latch, carry_flag,
    signed_overflow_flag, nibble_carry_flag, branch_taken, op_done, port_read_bit,
    port_read_byte, div_by_zero};
  afp_alu_flags u_dut (.clock, .rst_b, .op_valid, .op_code, .src_operand, .dst_operand,
    .port_bit_sel, .port_pins, .accumulator_reg, .b_reg, .port_latch, .carry_flag,
    .signed_overflow_flag, .nibble_carry_flag, .branch_taken, .port_read_bit,
    .port_read_byte, .div_by_zero, .op_done);
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task automatic end_sim;
    if (failures == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles > 12000) begin
      failures++;
      end_sim();
    end
  end
  // returns carry, overflow, nibble carry, result
  function automatic logic [10:0] arith(input logic [7:0] a, s, input logic ci, sb);
    logic [4:0] lo;
    logic [7:0] mid;
    logic [8:0] f;
    lo = sb ? {1'b0, a[3:0]} - s[3:0] - ci : {1'b0, a[3:0]} + s[3:0] + ci;
    mid = sb ? {1'b0, a[6:0]} - s[6:0] - ci : {1'b0, a[6:0]} + s[6:0] + ci;
    f = sb ? {1'b0, a} - s - ci : {1'b0, a} + s + ci;
    return {f[8], mid[7] ^ f[8], lo[4], f[7:0]};
  endfunction
  task automatic chk(input logic br, dn);
    logic [38:0] e;
    e = {m_acc, m_b, m_lat, m_c, m_ov, m_ac, br, dn, m_rbit, m_rbyte, m_dz};
    check_count++;
    if (seen !== e) begin
      failures++;
      $display("mismatch outputs expected %h seen %h", e, seen);
    end
  endtask
  task automatic op(input logic [4:0] code, input logic [7:0] s, input logic [7:0] d = 8'h00);
    logic [8:0]  t;
    logic [15:0] p;
    logic        br;
    logic [2:0]  k;
    logic        z;
    op_valid = 1'b1;
    op_code = code;
    src_operand = s;
    dst_operand = d;
    {port_bit_sel, port_pins} = 11'($random(seed));
    k = port_bit_sel;
    br = 1'b0;
    @(posedge clock);
    case (code)
      `AFP_OP_ADD, `AFP_OP_ADD_WITH_CARRY_OP, `AFP_OP_SUB:
        {m_c, m_ov, m_ac, m_acc} = arith(m_acc, s, m_c & (code != `AFP_OP_ADD), code == `AFP_OP_SUB);
      `AFP_OP_MUL: begin
        p = m_acc * m_b;
        {m_b, m_acc} = p;
        {m_c, m_ov} = {1'b0, p > 16'h00ff};
      end
      `AFP_OP_DIV: begin
        z = (m_b == 8'h00);
        {m_c, m_ov, m_dz} = {1'b0, z, z};
        if (z) {m_acc, m_b} = {8'hff, m_acc};
        else {m_acc, m_b} = {m_acc / m_b, m_acc % m_b};
      end
      `AFP_OP_DADJ: begin
        t = {1'b0, m_acc};
        if (m_ac || m_acc[3:0] > 4'h9) t = t + 9'h006;
        if (m_c || m_ac || m_acc[3:0] > 4'h9) t = t + 9'h060;
        m_c = (t > 9'h099);
        m_acc = t[7:0];
      end
      `AFP_OP_RRC: {m_acc, m_c} = {m_c, m_acc};
      `AFP_OP_RLC: {m_c, m_acc} = {m_acc, m_c};
      `AFP_OP_CMPBR: {br, m_c} = {s != d, s > d};
      `AFP_OP_P_AND: m_lat = m_lat & s;
      `AFP_OP_P_OR: m_lat = m_lat | s;
      `AFP_OP_P_XOR: m_lat = m_lat ^ s;
      `AFP_OP_P_TBCJ: {br, m_lat[k]} = {m_lat[k], 1'b0};
      `AFP_OP_P_CPL: m_lat[k] = ~m_lat[k];
      `AFP_OP_P_INC: m_lat = m_lat + 8'h01;
      `AFP_OP_P_DEC: m_lat = m_lat - 8'h01;
      `AFP_OP_P_DECREMENT_JUMP_NONZERO_OP: {m_lat, br} = {m_lat - 8'h01, m_lat != 8'h01};
      `AFP_OP_P_MOVC: m_lat[k] = m_c;
      `AFP_OP_P_CLRB: m_lat[k] = 1'b0;
      `AFP_OP_P_BIT_SET_OP: m_lat[k] = 1'b1;
      `AFP_OP_P_RDBIT: m_rbit = port_pins[k];
      `AFP_OP_P_RDBYTE: m_rbyte = port_pins;
      `AFP_OP_CPLBYTE: m_acc = ~m_acc;
      default: ;
    endcase
    @(negedge clock);
    chk(br, 1'b1);
  endtask
  task automatic ld(input logic [7:0] x);
    op(`AFP_OP_ADD, x - m_acc);
  endtask
  task automatic reset_dut;
    op_valid = 1'b0;
    rst_b = 1'b0;
    repeat (8) @(negedge clock);
    rst_b = 1'b1;
    {m_acc, m_b, m_lat, m_c, m_ov, m_ac, m_rbit, m_rbyte, m_dz} = {24'h0000ff, 13'h0000};
    chk(1'b0, 1'b0);
  endtask
  initial begin
    {failures, check_count, seed} = {32'h0, 32'h0, 32'h4de8};
    {op_code, src_operand, dst_operand, port_bit_sel, port_pins} = 32'h0;
    reset_dut();
    ld(8'hff);
    op(`AFP_OP_DIV, 8'h00);
    op(`AFP_OP_MUL, 8'h00);
    op(`AFP_OP_DIV, 8'h00);
    ld(8'hff);
    op(`AFP_OP_ADD, 8'h01);
    op(`AFP_OP_ADD_WITH_CARRY_OP, 8'h7f);
    ld(8'h00);
    op(`AFP_OP_SUB, 8'h01);
    op(`AFP_OP_SUB, 8'h7f);
    ld(8'h38);
    op(`AFP_OP_ADD, 8'h29);
    op(`AFP_OP_DADJ, 8'h00);
    ld(8'h99);
    op(`AFP_OP_ADD, 8'h01);
    op(`AFP_OP_DADJ, 8'h00);
    op(`AFP_OP_DADJ, 8'h00);
    op(`AFP_OP_CMPBR, 8'h5a, 8'h5a);
    op(`AFP_OP_CMPBR, 8'ha5, 8'h5a);
    for (i = `AFP_OP_P_AND; i <= `AFP_OP_CPLBYTE; i++)
      op(5'(i), 8'($random(seed)));
    repeat (3000) op(5'($random(seed)), 8'($random(seed)), 8'($random(seed)));
    reset_dut();
    repeat (3000) op(5'($random(seed)), 8'($random(seed)), 8'($random(seed)));
    end_sim();
  end
endmodule // tb
`default_nettype wire
